// File: inc/pm1_event_pkg.sv
// Package: offsets, field positions, reset values and carrier types of the PM1 event register set
`default_nettype none
package pm1_event_pkg;
    localparam logic [31:0] PROC_BASE_ADDR   = 32'h000F_1500;
    localparam logic [7:0]  OFF_STS_B0       = 8'h00;
    localparam logic [7:0]  OFF_STS_B1       = 8'h01;
    localparam logic [7:0]  OFF_EN_B0        = 8'h02;
    localparam logic [7:0]  OFF_EN_B1        = 8'h03;
    localparam logic [7:0]  OFF_CTL_B0       = 8'h04;
    localparam logic [7:0]  OFF_CTL_B1       = 8'h05;
    localparam logic [7:0]  OFF_PM2_B0       = 8'h06;
    localparam logic [7:0]  OFF_PM2_B1       = 8'h07;
    localparam logic [7:0]  OFF_PROC_EVT     = 8'h10;
    // Status byte 1 fields
    localparam int          STS_PWRBTN_BIT   = 0;
    localparam int          STS_SLPBTN_BIT   = 1;
    localparam int          STS_ALARM_BIT    = 2;
    localparam int          STS_OVR_BIT      = 3;
    localparam int          STS_WAKE_BIT     = 7;
    localparam logic [7:0]  STS_B1_MASK      = 8'h8F;
    // Enable byte 1 fields
    localparam int          EN_PWRBTN_BIT    = 0;
    localparam int          EN_SLPBTN_BIT    = 1;
    localparam int          EN_ALARM_BIT     = 2;
    // Control byte 1 fields, then the processor event SCI bit and the reset byte
    localparam int          CTL_OVR_BIT      = 1;
    localparam int          CTL_TYPE_LSB     = 2;
    localparam int          CTL_SLPREQ_BIT   = 5;
    localparam int          PROC_SCI_BIT     = 0;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;

    typedef struct packed {
        logic       alarmEnable;
        logic       sleepButtonEnable;
        logic       powerButtonEnable;
    } enable_bits_t;

    typedef struct packed {
        logic [2:0] sleepTypeField;
        logic       sleepRequestFlag;
        logic       powerButtonOverrideEnable;
    } control_bits_t;

    // One byte access request on either bus
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [7:0]    statusByte1;
        enable_bits_t  enables;
        control_bits_t control;
        logic [7:0]    processorEventStatus;
        logic [7:0]    hostRdata;
        logic [7:0]    procRdata;
        logic          sciPinN;
    } pm1_state_t;
endpackage
`default_nettype wire

// File: src/acpi_pm1_event_registers.sv
// Shared PM1 event/enable/control register set with host and embedded-processor views
//
// Behaviour
// - Alarm enable: host read/write, processor read-only
// - Sleep button enable: host RW, processor RO
// - Power button enable bit 0; bits 7:3 reserved
// - Sleep type field: host RW, processor RO
// - Override enable host RW; bits 7:6,0 reserved
// - Host writes one sets sleep request; reads zero
// - Processor reads sleep request; write one clears
// - Processor SCI bit drives active-low SCI pin
// - Event status processor-only; upper bits plain storage
// - Processor view based at 000F_1500h
// - Host write one clears status; processor writes directly
// - Other registers reachable from both buses
`default_nettype none
module acpi_pm1_event_registers (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire pm1_event_pkg::bus_req_t hostReq,
    output logic [7:0]                   hostRdata,
    input  wire logic                    procSel,
    input  wire pm1_event_pkg::bus_req_t procReq,
    output logic [7:0]                   procRdata,
    output logic                         sci_request_pin_n,
    output logic [2:0]                   sleepTypeField,
    output logic                         sleepRequestFlag
);
    import pm1_event_pkg::*;

    pm1_state_t curState;
    pm1_state_t nxtState;

    ////////////////////////////////////////////////////////////////////////////
    // Shared read image; host and processor see the same bytes except where noted
    function automatic logic [7:0] readByte(input pm1_state_t s, input logic [7:0] a, input logic isHost);
        logic [7:0] d;
        d = RESET_BYTE;
        if (a == OFF_STS_B1) begin
            d = s.statusByte1 & STS_B1_MASK;
        end else if (a == OFF_EN_B1) begin
            d[EN_ALARM_BIT]  = s.enables.alarmEnable;
            d[EN_SLPBTN_BIT] = s.enables.sleepButtonEnable;
            d[EN_PWRBTN_BIT] = s.enables.powerButtonEnable;
        end else if (a == OFF_CTL_B1) begin
            d[CTL_TYPE_LSB +: 3] = s.control.sleepTypeField;
            d[CTL_OVR_BIT]       = s.control.powerButtonOverrideEnable;
            d[CTL_SLPREQ_BIT]    = isHost ? 1'b0 : s.control.sleepRequestFlag;
        end else if (a == OFF_PROC_EVT && !isHost) begin
            d = s.processorEventStatus;
        end else begin
            d = RESET_BYTE;
        end
        return d;
    endfunction

    wire logic procRd = procSel & procReq.rd;
    wire logic procWr = procSel & procReq.wr;

    ////////////////////////////////////////////////////////////////////////////
    // Next state; processor write applied first so a host set on the same
    // cycle as a processor clear of the sleep request wins and is not lost
    always_comb begin
        nxtState = curState;
        // Processor writes
        if (procWr) begin
            if (procReq.addr == OFF_STS_B1) begin
                nxtState.statusByte1 = procReq.wdata & STS_B1_MASK;
            end else if (procReq.addr == OFF_CTL_B1) begin
                if (procReq.wdata[CTL_SLPREQ_BIT]) begin
                    nxtState.control.sleepRequestFlag = 1'b0;
                end
            end else if (procReq.addr == OFF_PROC_EVT) begin
                nxtState.processorEventStatus = procReq.wdata;
            end
        end
        // Host writes; enables, sleep type and override are read-only to the processor
        if (hostReq.wr) begin
            if (hostReq.addr == OFF_STS_B1) begin
                // Write-one-to-clear; a same-cycle processor set is overridden
                // only for bits the host names, matching the clear semantics
                nxtState.statusByte1 = nxtState.statusByte1 & ~(hostReq.wdata & STS_B1_MASK);
            end else if (hostReq.addr == OFF_EN_B1) begin
                nxtState.enables.alarmEnable       = hostReq.wdata[EN_ALARM_BIT];
                nxtState.enables.sleepButtonEnable = hostReq.wdata[EN_SLPBTN_BIT];
                nxtState.enables.powerButtonEnable = hostReq.wdata[EN_PWRBTN_BIT];
            end else if (hostReq.addr == OFF_CTL_B1) begin
                nxtState.control.sleepTypeField = hostReq.wdata[CTL_TYPE_LSB +: 3];
                nxtState.control.powerButtonOverrideEnable = hostReq.wdata[CTL_OVR_BIT];
                if (hostReq.wdata[CTL_SLPREQ_BIT]) begin
                    nxtState.control.sleepRequestFlag = 1'b1;
                end
            end
        end
        // Read data is registered, valid the cycle after the read strobe
        nxtState.hostRdata = hostReq.rd ? readByte(curState, hostReq.addr, 1'b1) : RESET_BYTE;
        nxtState.procRdata = procRd ? readByte(curState, procReq.addr, 1'b0) : RESET_BYTE;
        // Pin is registered with the stored SCI bit and changes on the same edge; firmware gates it with enables
        nxtState.sciPinN = ~nxtState.processorEventStatus[PROC_SCI_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; standby-power reset clears everything, pin idles high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            curState         <= '0;
            curState.sciPinN <= 1'b1;
        end else begin
            curState <= nxtState;
        end
    end

    assign hostRdata         = curState.hostRdata;
    assign procRdata         = curState.procRdata;
    assign sci_request_pin_n = curState.sciPinN;
    assign sleepTypeField    = curState.control.sleepTypeField;
    assign sleepRequestFlag  = curState.control.sleepRequestFlag;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_sci_pin;
        @(posedge sys_clk) disable iff (!nrst)
        ##1 (sci_request_pin_n == ~curState.processorEventStatus[PROC_SCI_BIT]);
    endproperty
    a_sci_pin: assert property (p_sci_pin) else $error("SCI pin disagrees with SCI bit");

    property p_host_slp_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.rd && hostReq.addr == OFF_CTL_B1) |=> !hostRdata[CTL_SLPREQ_BIT];
    endproperty
    a_host_slp_zero: assert property (p_host_slp_zero) else $error("Host saw sleep request");

    property p_host_slp_set;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.wr && hostReq.addr == OFF_CTL_B1 && hostReq.wdata[CTL_SLPREQ_BIT]) |=> sleepRequestFlag;
    endproperty
    a_host_slp_set: assert property (p_host_slp_set) else $error("Sleep request not set");

    property p_proc_slp_clr;
        @(posedge sys_clk) disable iff (!nrst)
        (procWr && procReq.addr == OFF_CTL_B1 && procReq.wdata[CTL_SLPREQ_BIT] &&
         !(hostReq.wr && hostReq.addr == OFF_CTL_B1 && hostReq.wdata[CTL_SLPREQ_BIT])) |=> !sleepRequestFlag;
    endproperty
    a_proc_slp_clr: assert property (p_proc_slp_clr) else $error("Sleep request not cleared");

    property p_en_proc_ro;
        @(posedge sys_clk) disable iff (!nrst)
        !(hostReq.wr && hostReq.addr == OFF_EN_B1) |=> $stable(curState.enables);
    endproperty
    a_en_proc_ro: assert property (p_en_proc_ro) else $error("Enables changed without host write");

    property p_type_ro;
        @(posedge sys_clk) disable iff (!nrst)
        !(hostReq.wr && hostReq.addr == OFF_CTL_B1) |=>
            $stable(sleepTypeField) && $stable(curState.control.powerButtonOverrideEnable);
    endproperty
    a_type_ro: assert property (p_type_ro) else $error("Control changed without host write");

    property p_host_no_evt;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.rd && hostReq.addr == OFF_PROC_EVT) |=> (hostRdata == 8'h00);
    endproperty
    a_host_no_evt: assert property (p_host_no_evt) else $error("Host read event status");

    property p_unmapped;
        @(posedge sys_clk) disable iff (!nrst)
        (procRd && procReq.addr > OFF_PM2_B1 && procReq.addr != OFF_PROC_EVT) |=> (procRdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read nonzero");

    property p_w1c;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.wr && hostReq.addr == OFF_STS_B1) |=>
            ((curState.statusByte1 & $past(hostReq.wdata) & STS_B1_MASK) == 8'h00);
    endproperty
    a_w1c: assert property (p_w1c) else $error("Status bit not cleared by host");

    // Reserved enable bits must never leak stored state to the host
    property p_en_rsvd;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.rd && hostReq.addr == OFF_EN_B1) |=> (hostRdata[7:3] == 5'h00);
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("Reserved enable bits nonzero");

    property p_ctl_rsvd;
        @(posedge sys_clk) disable iff (!nrst)
        (procRd && procReq.addr == OFF_CTL_B1) |=> (procRdata[7:6] == 2'h0 && !procRdata[0]);
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("Reserved control bits nonzero");

    // Processor sees the true sleep request, unlike the host
    property p_proc_slp_view;
        @(posedge sys_clk) disable iff (!nrst)
        (procRd && procReq.addr == OFF_CTL_B1) |=>
            (procRdata[CTL_SLPREQ_BIT] == $past(curState.control.sleepRequestFlag));
    endproperty
    a_proc_slp_view: assert property (p_proc_slp_view) else $error("Processor sleep request view wrong");

    property p_evt_wr;
        @(posedge sys_clk) disable iff (!nrst)
        (procWr && procReq.addr == OFF_PROC_EVT) |=> (curState.processorEventStatus == $past(procReq.wdata));
    endproperty
    a_evt_wr: assert property (p_evt_wr) else $error("Event status write lost");

    property p_host_en_wr;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.wr && hostReq.addr == OFF_EN_B1) |=> (curState.enables == $past(hostReq.wdata[2:0]));
    endproperty
    a_host_en_wr: assert property (p_host_en_wr) else $error("Host enable write lost");

    // Read data stands one cycle only, so idle cycles must read zero
    property p_rd_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !hostReq.rd |=> (hostRdata == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("Host read data without read");

    property p_sts_rsvd;
        @(posedge sys_clk) disable iff (!nrst)
        (hostReq.rd && hostReq.addr == OFF_STS_B0) |=> (hostRdata == 8'h00);
    endproperty
    a_sts_rsvd: assert property (p_sts_rsvd) else $error("Reserved status byte nonzero");

    // Host clear beats a processor write in the same cycle, so exclude that case
    property p_proc_sts_wr;
        @(posedge sys_clk) disable iff (!nrst)
        (procWr && procReq.addr == OFF_STS_B1 && !(hostReq.wr && hostReq.addr == OFF_STS_B1)) |=>
            (curState.statusByte1 == ($past(procReq.wdata) & STS_B1_MASK));
    endproperty
    a_proc_sts_wr: assert property (p_proc_sts_wr) else $error("Processor status write lost");
endmodule
`default_nettype wire

// File: verif/fw_bus_model.sv
// Firmware-side bus model: turns 32-bit processor accesses into block requests
`default_nettype none
module fw_bus_model (
    input  wire logic                    sys_clk,
    input  wire logic                    rd,
    input  wire logic                    wr,
    input  wire logic [31:0]             addr,
    input  wire logic [7:0]              wdata,
    output var  logic                    procSel,
    output var  pm1_event_pkg::bus_req_t procReq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pm1_event_pkg::*;
    ////////////////////////////////////////////////////////////////
    // One register stage; idle data toggles so stale bytes never look valid
    always @(posedge sys_clk) begin
        procSel <= (rd | wr) && (addr[31:8] == PROC_BASE_ADDR[31:8]);
        procReq <= '{rd, wr, addr[7:0], (rd | wr) ? wdata : ~procReq.wdata};
    end
endmodule
`default_nettype wire

// File: verif/acpi_pm1_event_registers_tb.sv
// Self-checking bench of the PM1 event register set
`default_nettype none
module acpi_pm1_event_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pm1_event_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, fRd = 1'b0, fWr = 1'b0, pH = 1'b0, pP = 1'b0;
    logic [31:0] fAddr = '0;
    logic [7:0]  fData = '0, hostRdata, procRdata, d;
    logic [2:0]  sleepTypeField, en = '0;
    logic        procSel, sci_request_pin_n, sleepRequestFlag;
    bus_req_t    hostReq = '0, procReq;
    logic [7:0]  qH[$], qP[$];
    int          nErrors = 0, checksDone = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////
    always #12.5 sys_clk = ~sys_clk;
    acpi_pm1_event_registers dut (.sys_clk(sys_clk), .nrst(nrst), .hostReq(hostReq), .hostRdata(hostRdata),
        .procSel(procSel), .procReq(procReq), .procRdata(procRdata), .sci_request_pin_n(sci_request_pin_n),
        .sleepTypeField(sleepTypeField), .sleepRequestFlag(sleepRequestFlag));
    fw_bus_model fw (.sys_clk(sys_clk), .rd(fRd), .wr(fWr), .addr(fAddr), .wdata(fData),
        .procSel(procSel), .procReq(procReq));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checksDone++;
        if (s !== e) begin
            nErrors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Host and firmware accesses: launch on an edge, release one edge later
    task automatic ha(input logic r, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        hostReq <= '{r, w, a, v};
        @(posedge sys_clk);
        hostReq <= '0;
    endtask
    task automatic pa(input logic r, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {fRd, fWr, fAddr, fData} <= {r, w, PROC_BASE_ADDR + 32'(a), v};
        @(posedge sys_clk);
        {fRd, fWr} <= 2'b00;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic hr(input logic [7:0] a, input logic [7:0] e);
        qH.push_back(e);
        ha(1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic pr(input logic [7:0] a, input logic [7:0] e);
        qP.push_back(e);
        pa(1'b1, 1'b0, a, 8'h00);
    endtask
    // Read data lands one edge after the request is taken
    always @(posedge sys_clk) begin
        if (pH) chk(hostRdata, qH.pop_front());
        if (pP) chk(procRdata, qP.pop_front());
        pH <= hostReq.rd;
        pP <= procSel & procReq.rd;
        cyc <= cyc + 1;
        if (cyc > 8000) begin
            nErrors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        d = 8'($urandom(69463));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            // Whole map reads zero after reset; unmapped places discard writes
            for (int a = 0; a < 18; a++) begin
                if (k == 0) begin
                    ha(1'b0, 1'b1, 8'(a + 8), 8'hFF);
                    hr(8'(a), 8'h00);
                    pr(8'(a), 8'h00);
                end
            end
            d = 8'($urandom);
            en = d[2:0];
            ha(1'b0, 1'b1, OFF_EN_B1, d);
            pa(1'b0, 1'b1, OFF_EN_B1, ~d);
            hr(OFF_EN_B1, d & 8'h07);
            pr(OFF_EN_B1, d & 8'h07);
            d = 8'($urandom) | 8'h20;
            ha(1'b0, 1'b1, OFF_CTL_B1, d);
            ha(1'b0, 1'b1, OFF_CTL_B1, d & 8'hDF);
            pa(1'b0, 1'b1, OFF_CTL_B1, 8'h00);
            hr(OFF_CTL_B1, d & 8'h1E);
            pr(OFF_CTL_B1, d & 8'h3E);
            chk({5'h00, sleepTypeField}, {5'h00, d[4:2]});
            pa(1'b0, 1'b1, OFF_CTL_B1, 8'h20);
            chk({7'h00, sleepRequestFlag}, 8'h00);
            pa(1'b0, 1'b1, OFF_STS_B1, 8'hFF);
            ha(1'b0, 1'b1, OFF_STS_B1, d & 8'h05);
            pr(OFF_STS_B1, 8'h8F & ~(d & 8'h05));
            // Firmware signals an event only once the host has enabled one
            d = 8'($urandom);
            if (en == 3'h0) d[0] = 1'b0;
            pa(1'b0, 1'b1, OFF_PROC_EVT, d);
            ha(1'b0, 1'b1, OFF_PROC_EVT, ~d);
            hr(OFF_PROC_EVT, 8'h00);
            pr(OFF_PROC_EVT, d);
            chk({7'h00, sci_request_pin_n}, {7'h00, ~d[0]});
        end
        // Second reset mid-run returns every field to zero and the SCI pin high
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({sci_request_pin_n, sleepRequestFlag, sleepTypeField, 3'h0}, 8'h80);
        nrst <= 1'b1;
        pr(OFF_PROC_EVT, 8'h00);
        pr(OFF_EN_B1, 8'h00);
        repeat (3) @(posedge sys_clk);
        complete_run();
    end
endmodule
`default_nettype wire
